// *** design/fcs_pkg.sv ***
// Purpose: Shared constants of the flash command sequencer
// Assumes: 100 MHz system clock, 32-bit classic Wishbone slave
// Notes:   Offsets are byte addresses of aligned words
package fcs_pkg;
   localparam logic [7:0]  OFF_MODE      = 8'h00;
   localparam logic [7:0]  OFF_CMD       = 8'h04;
   localparam logic [7:0]  OFF_STATUS    = 8'h08;
   localparam logic [7:0]  OFF_RESULT    = 8'h0c;
   localparam int          MODE_IE_BIT   = 0;
   localparam int          MODE_FWS_LSB  = 8;
   localparam int          FWS_W         = 4;
   localparam logic [3:0]  FWS_RST       = 4'h0;
   localparam logic        IE_RST        = 1'b0;
   localparam int          CMD_KEY_LSB   = 24;
   localparam int          CMD_ARG_LSB   = 8;
   localparam int          ARG_W         = 16;
   localparam int          ST_RDY_BIT    = 0;
   localparam int          ST_CMDE_BIT   = 1;
   localparam int          ST_LOCKE_BIT  = 2;
   localparam int          LINE_W        = 128;
   localparam int          CLK_NS        = 10;
   localparam int          PROG_NS       = 4600000;
   localparam int          ERASE_ALL_NS  = 10000000;
   localparam int          BIT_OP_NS     = 1000;
   localparam int          PROG_CYC      = (PROG_NS + CLK_NS - 1) / CLK_NS;
   localparam int          ERASE_ALL_CYC = (ERASE_ALL_NS + CLK_NS - 1)
                                           / CLK_NS;
   localparam int          BIT_OP_CYC    = (BIT_OP_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [3:0] {
      CMD_GET_DESC  = 4'h0,
      CMD_PROGRAM   = 4'h1,
      CMD_PROG_LOCK = 4'h2,
      CMD_ERASE_PRG = 4'h3,
      CMD_ERASE_PL  = 4'h4,
      CMD_WIPE      = 4'h5,
      CMD_SET_LOCK  = 4'h8,
      CMD_CLR_LOCK  = 4'h9,
      CMD_RD_LOCK   = 4'ha,
      CMD_SET_NV    = 4'hb,
      CMD_CLR_NV    = 4'hc,
      CMD_RD_NV     = 4'hd
   } fcs_cmd_t;
endpackage

// *** design/fcs_read_buf.sv ***
// Purpose: 128-bit line read path with two code and one data buffer
// Assumes: Requester holds rd_req_i until rd_ack_o, array line valid
//          on fl_line_i when the wait-state count runs out
// Notes:   Ack and data are registered
module fcs_read_buf #(
   parameter int ADDR_W      = 17,
   parameter int NUM_PLANES  = 1
) (
   input  wire logic                  sys_clk_i,
   input  wire logic                  rst_n_i,
   input  wire logic [3:0]            fws_i,
   input  wire logic [NUM_PLANES-1:0] plane_busy_i,
   input  wire logic                  rd_req_i,
   input  wire logic                  rd_instr_i,
   input  wire logic [ADDR_W-1:0]     rd_addr_i,
   output logic                       rd_ack_o,
   output logic [31:0]                rd_data_o,
   output logic                       fl_req_o,
   output logic [ADDR_W-5:0]          fl_line_addr_o,
   input  wire logic [127:0]          fl_line_i
);
   localparam int TW = ADDR_W - 4;
   localparam int PLANE_LINES = (1 << TW) / NUM_PLANES;
   if (ADDR_W < 6 || NUM_PLANES < 1 || PLANE_LINES < 1) begin : g_chk
      $error("fcs_read_buf: unsupported geometry");
   end
   typedef struct packed {
      logic [1:0][127:0] ib_data;
      logic [1:0][TW-1:0] ib_tag;
      logic [1:0]        ib_v;
      logic              ib_nxt;
      logic [127:0]      db_data;
      logic [TW-1:0]     db_tag;
      logic              db_v;
      logic              fe_busy;
      logic              fe_done;
      logic [3:0]        fe_cnt;
      logic [TW-1:0]     fe_tag;
      logic [127:0]      fe_line;
      logic              ack;
      logic [31:0]       data;
   } fcs_rb_t;
   fcs_rb_t q_ff, nxt_q;

   function automatic logic plane_free(input logic [TW-1:0] t,
                                       input logic [NUM_PLANES-1:0] b);
      int p;
      p = int'(t) / PLANE_LINES;
      return !b[p];
   endfunction

   always_comb begin
      logic [TW-1:0] tag;
      logic [TW-1:0] tnx;
      logic [1:0]    w;
      logic          start;
      logic [TW-1:0] stag;
      tag = rd_addr_i[ADDR_W-1:4];
      tnx = tag + 1'b1;
      w = rd_addr_i[3:2];
      start = 1'b0;
      stag = tag;
      nxt_q = q_ff;
      nxt_q.ack = 1'b0;
      if (q_ff.fe_busy) begin
         if (q_ff.fe_cnt == 4'h0) begin
            nxt_q.fe_busy = 1'b0;
            nxt_q.fe_done = 1'b1;
            nxt_q.fe_line = fl_line_i;
         end else begin
            nxt_q.fe_cnt = q_ff.fe_cnt - 4'h1;
         end
      end
      if (rd_req_i && !q_ff.ack) begin
         if (rd_instr_i) begin
            if (q_ff.ib_v[0] && q_ff.ib_tag[0] == tag) begin
               nxt_q.ack = 1'b1;
               nxt_q.data = q_ff.ib_data[0][w*32 +: 32];
            end else if (q_ff.ib_v[1] && q_ff.ib_tag[1] == tag) begin
               nxt_q.ack = 1'b1;
               nxt_q.data = q_ff.ib_data[1][w*32 +: 32];
            end else if (q_ff.fe_done && q_ff.fe_tag == tag) begin
               nxt_q.ack = 1'b1;
               nxt_q.data = q_ff.fe_line[w*32 +: 32];
               nxt_q.ib_data[q_ff.ib_nxt] = q_ff.fe_line; // [R2]
               nxt_q.ib_tag[q_ff.ib_nxt] = tag;
               nxt_q.ib_v[q_ff.ib_nxt] = 1'b1;
               nxt_q.ib_nxt = !q_ff.ib_nxt;
               nxt_q.fe_done = 1'b0;
               start = 1'b1;                   // Prefetch next line [R1]
               stag = tnx;
            end else begin
               start = 1'b1;
            end
         end else begin
            if (q_ff.db_v && q_ff.db_tag == tag) begin
               nxt_q.ack = 1'b1;
               nxt_q.data = q_ff.db_data[w*32 +: 32];
               if (w == 2'h1 && !(q_ff.fe_done && q_ff.fe_tag == tnx)) begin
                  start = 1'b1;                // Next line on second read [R3]
                  stag = tnx;
               end
            end else if (q_ff.fe_done && q_ff.fe_tag == tag) begin
               nxt_q.ack = 1'b1;
               nxt_q.data = q_ff.fe_line[w*32 +: 32];
               nxt_q.db_data = q_ff.fe_line;   // [R2]
               nxt_q.db_tag = tag;
               nxt_q.db_v = 1'b1;
               nxt_q.fe_done = 1'b0;
            end else begin
               start = 1'b1;
            end
         end
      end
      if (start && !q_ff.fe_busy && plane_free(stag, plane_busy_i)) begin
         nxt_q.fe_busy = 1'b1;                 // Busy plane holds off [R4]
         nxt_q.fe_done = 1'b0;
         nxt_q.fe_tag = stag;
         nxt_q.fe_cnt = (fws_i < 4'h2) ? 4'h0 : fws_i - 4'h2; // [R1]
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign rd_ack_o = q_ff.ack;
   assign rd_data_o = q_ff.data;
   assign fl_req_o = q_ff.fe_busy;
   assign fl_line_addr_o = q_ff.fe_tag;
endmodule // fcs_read_buf

// *** design/fcs_sequencer.sv ***
// Purpose: Keyed flash command sequencer with read buffering
// Assumes: Classic Wishbone master, one access at a time
// Notes:   Array timing is modelled by cycle counts
// Function
// R1 - Sequential reads: FLASH_WAIT_STATES+1, FLASH_WAIT_STATES-2, then 1
// R2 - 128-bit lines, two code, one data buffer
// R3 - Data read prefetches next line on second read
// R4 - Reads and commands only on different planes; a command write still starts while a line fetch is in progress
// R5 - Page write codes 0x1 to 0x4
// R6 - Wipe, lock and nonvolatile bit codes
// R7 - Code 0x0 starts descriptor readout
// R8 - Host writes opcode into command field
// R9 - Command write clears ready and result value
// R10 - Ready set when command finishes
// R11 - Ready with enable drives interrupt line
// R12 - Host puts key in top eight bits
// R13 - Bad key or code sets command error
// R14 - Locked page write or erase sets lock error
// R15 - First descriptor word shown once ready
// R16 - Each result read advances one word
// R17 - Past the end result reads zero
// R18 - Descriptor word order fixed
// R19 - Lock bits returned 32 per read
// R20 - Key and descriptor are design parameters
module fcs_sequencer #(
   parameter logic [7:0]  KEY        = 8'h5a,
   parameter logic [31:0] FLASH_ID   = 32'h0000_0001, // Arbitrary value
   parameter int          PAGE_BYTES = 256,
   parameter int          NUM_PAGES  = 512,
   parameter int          NUM_PLANES = 1,
   parameter int          NUM_LOCK   = 16,
   parameter int          NUM_NV     = 2,
   parameter int          ADDR_W     = 17,
   parameter int          PROG_CYC   = fcs_pkg::PROG_CYC,
   parameter int          WIPE_CYC   = fcs_pkg::ERASE_ALL_CYC
) (
   input  wire logic                  sys_clk_i,
   input  wire logic                  rst_n_i,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [7:0]            wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic [31:0]                wb_dat_o,
   output logic                       wb_ack_o,
   output logic                       irq_o,
   input  wire logic                  rd_req_i,
   input  wire logic                  rd_instr_i,
   input  wire logic [ADDR_W-1:0]     rd_addr_i,
   output logic                       rd_ack_o,
   output logic [31:0]                rd_data_o,
   output logic                       fl_req_o,
   output logic [ADDR_W-5:0]          fl_line_addr_o,
   input  wire logic [127:0]          fl_line_i,
   output logic [NUM_PLANES-1:0]      plane_busy_o,
   output logic [3:0]                 nvm_op_o,
   output logic [15:0]                nvm_page_o
);
   localparam int LOCK_WORDS = (NUM_LOCK + 31) / 32;
   localparam int DESC_N = 5 + NUM_PLANES + NUM_LOCK;
   localparam int REG_PAGES = NUM_PAGES / NUM_LOCK;
   localparam int PLANE_PAGES = NUM_PAGES / NUM_PLANES;
   localparam int FLASH_BYTES = PAGE_BYTES * NUM_PAGES;
   if (NUM_LOCK < 1 || NUM_LOCK > 200 || REG_PAGES < 1 ||
       NUM_PLANES < 1 || PLANE_PAGES < 1 || NUM_NV < 1 || NUM_NV > 32 ||
       PROG_CYC < 1 || WIPE_CYC < 1 || PROG_CYC >= (1 << 24) ||
       WIPE_CYC >= (1 << 24) || FLASH_BYTES > (1 << ADDR_W))
   begin : g_chk
      $error("fcs_sequencer: unsupported parameters");
   end

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_EXEC   = 3'b010,
      ST_FINISH = 3'b100
   } fcs_state_t;

   typedef enum logic [3:0] {
      RES_NONE = 4'b0001,
      RES_DESC = 4'b0010,
      RES_LOCK = 4'b0100,
      RES_NV   = 4'b1000
   } fcs_res_t;

   typedef struct packed {
      logic                ack;
      logic [31:0]         dat;
      logic                ie;
      logic [3:0]          flash_wait_states;
      logic                ready;
      logic                cmd_err;
      logic                lock_err;
      fcs_state_t          st;
      fcs_pkg::fcs_cmd_t   cmd;
      logic [15:0]         arg;
      logic [23:0]         cnt;
      fcs_res_t            kind;
      logic [7:0]          idx;
      logic [NUM_LOCK-1:0] locks;
      logic [NUM_NV-1:0]   nv;
   } fcs_regs_t;

   fcs_regs_t q_ff, nxt_q;

   function automatic logic [31:0] desc_word(input logic [7:0] i);
      int k;
      k = int'(i);
      if (k == 0) return FLASH_ID;                              // [R18]
      if (k == 1) return 32'(FLASH_BYTES);
      if (k == 2) return 32'(PAGE_BYTES);
      if (k == 3) return 32'(NUM_PLANES);
      if (k < 4 + NUM_PLANES) return 32'(PLANE_PAGES * PAGE_BYTES);
      if (k == 4 + NUM_PLANES) return 32'(NUM_LOCK);
      if (k < DESC_N) return 32'(REG_PAGES * PAGE_BYTES);
      return 32'h0000_0000;
   endfunction

   function automatic logic [31:0] res_word(input fcs_regs_t r);
      logic [LOCK_WORDS*32-1:0] lp;
      lp = '0;
      lp[NUM_LOCK-1:0] = r.locks;
      res_word = 32'h0000_0000;
      if (r.ready) begin                       // Zero while busy [R9]
         case (r.kind)
            RES_DESC: res_word = desc_word(r.idx);             // [R15]
            RES_LOCK: begin
               if (int'(r.idx) < LOCK_WORDS) begin
                  res_word = lp[int'(r.idx)*32 +: 32];          // [R19]
               end
            end
            RES_NV: begin
               if (r.idx == 8'h00) begin
                  res_word = 32'(r.nv);
               end
            end
            default: res_word = 32'h0000_0000;
         endcase
      end
   endfunction

   function automatic int res_len(input fcs_res_t k);
      case (k)
         RES_DESC: res_len = DESC_N;
         RES_LOCK: res_len = LOCK_WORDS;
         RES_NV:   res_len = 1;
         default:  res_len = 0;
      endcase
   endfunction

   function automatic logic code_ok(input logic [3:0] c);
      case (c)
         4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha, 4'hb,
         4'hc, 4'hd: code_ok = 1'b1;                     // [R5] [R6] [R7]
         default:    code_ok = 1'b0;
      endcase
   endfunction

   function automatic logic is_page_op(input logic [3:0] c);
      return c == fcs_pkg::CMD_PROGRAM || c == fcs_pkg::CMD_PROG_LOCK ||
             c == fcs_pkg::CMD_ERASE_PRG || c == fcs_pkg::CMD_ERASE_PL;
   endfunction

   function automatic logic [23:0] op_cycles(input logic [3:0] c);
      if (is_page_op(c)) return 24'(PROG_CYC);
      if (c == fcs_pkg::CMD_WIPE) return 24'(WIPE_CYC);
      if (c == fcs_pkg::CMD_GET_DESC || c == fcs_pkg::CMD_RD_LOCK ||
          c == fcs_pkg::CMD_RD_NV) return 24'h00_0001;
      return 24'(fcs_pkg::BIT_OP_CYC);
   endfunction

   always_comb begin
      logic        acc;
      logic [3:0]  code;
      logic [15:0] arg;
      int          reg_i;
      int          page_i;
      acc = wb_cyc_i && wb_stb_i && !q_ff.ack;
      code = wb_dat_i[3:0];
      arg = wb_dat_i[fcs_pkg::CMD_ARG_LSB +: fcs_pkg::ARG_W];
      reg_i = int'(arg) / REG_PAGES;
      page_i = int'(q_ff.arg);
      nxt_q = q_ff;
      nxt_q.ack = acc;
      case (q_ff.st)
         ST_IDLE: begin
         end
         ST_EXEC: begin
            if (q_ff.cnt <= 24'h00_0001) begin
               nxt_q.st = ST_IDLE;
               nxt_q.ready = 1'b1;                          // [R10]
               nxt_q.idx = 8'h00;
               case (q_ff.cmd)
                  fcs_pkg::CMD_GET_DESC: nxt_q.kind = RES_DESC; // [R7]
                  fcs_pkg::CMD_RD_LOCK:  nxt_q.kind = RES_LOCK; // [R19]
                  fcs_pkg::CMD_RD_NV:    nxt_q.kind = RES_NV;
                  fcs_pkg::CMD_PROG_LOCK, fcs_pkg::CMD_ERASE_PL,
                  fcs_pkg::CMD_SET_LOCK: begin
                     if (page_i / REG_PAGES < NUM_LOCK) begin
                        nxt_q.locks[page_i / REG_PAGES] = 1'b1;
                     end
                  end
                  fcs_pkg::CMD_CLR_LOCK: begin
                     if (page_i / REG_PAGES < NUM_LOCK) begin
                        nxt_q.locks[page_i / REG_PAGES] = 1'b0;
                     end
                  end
                  fcs_pkg::CMD_SET_NV: begin
                     if (page_i < NUM_NV) begin
                        nxt_q.nv[page_i] = 1'b1;
                     end
                  end
                  fcs_pkg::CMD_CLR_NV: begin
                     if (page_i < NUM_NV) begin
                        nxt_q.nv[page_i] = 1'b0;
                     end
                  end
                  default: begin
                  end
               endcase
            end else begin
               nxt_q.cnt = q_ff.cnt - 24'h00_0001;
            end
         end
         ST_FINISH: begin
            nxt_q.st = ST_IDLE;
            nxt_q.ready = 1'b1;                             // [R10]
         end
         default: nxt_q.st = ST_IDLE;
      endcase
      if (acc && wb_we_i) begin
         case (wb_adr_i)
            fcs_pkg::OFF_MODE: begin
               if (wb_sel_i[0]) begin
                  nxt_q.ie = wb_dat_i[fcs_pkg::MODE_IE_BIT];
               end
               if (wb_sel_i[1]) begin
                  nxt_q.flash_wait_states = wb_dat_i[fcs_pkg::MODE_FWS_LSB +:
                                       fcs_pkg::FWS_W];
               end
            end
            fcs_pkg::OFF_CMD: begin
               if (wb_sel_i == 4'hf && q_ff.st == ST_IDLE) begin
                  nxt_q.ready = 1'b0;                       // [R9]
                  nxt_q.kind = RES_NONE;
                  nxt_q.idx = 8'h00;
                  nxt_q.cmd = fcs_pkg::fcs_cmd_t'(code);
                  nxt_q.arg = arg;
                  nxt_q.cnt = op_cycles(code);
                  nxt_q.st = ST_EXEC;
                  if (wb_dat_i[31:fcs_pkg::CMD_KEY_LSB] != KEY || // [R20]
                      !code_ok(code)) begin                 // [R12] [R13]
                     nxt_q.cmd_err = 1'b1;
                     nxt_q.st = ST_FINISH;
                  end else if ((is_page_op(code) && reg_i < NUM_LOCK &&
                               q_ff.locks[reg_i]) ||
                               (code == fcs_pkg::CMD_WIPE &&
                               (|q_ff.locks))) begin         // [R14]
                     nxt_q.lock_err = 1'b1;
                     nxt_q.st = ST_FINISH;
                  end
               end
            end
            default: begin
            end
         endcase
      end
      if (acc && !wb_we_i) begin
         case (wb_adr_i)
            fcs_pkg::OFF_MODE: begin
               nxt_q.dat = 32'h0000_0000;
               nxt_q.dat[fcs_pkg::MODE_IE_BIT] = q_ff.ie;
               nxt_q.dat[fcs_pkg::MODE_FWS_LSB +: fcs_pkg::FWS_W] = q_ff.flash_wait_states;
            end
            fcs_pkg::OFF_STATUS: begin
               nxt_q.dat = 32'h0000_0000;
               nxt_q.dat[fcs_pkg::ST_RDY_BIT] = q_ff.ready;
               nxt_q.dat[fcs_pkg::ST_CMDE_BIT] = q_ff.cmd_err;
               nxt_q.dat[fcs_pkg::ST_LOCKE_BIT] = q_ff.lock_err;
               nxt_q.cmd_err = 1'b0;                        // [R13]
               nxt_q.lock_err = 1'b0;                       // [R14]
            end
            fcs_pkg::OFF_RESULT: begin
               nxt_q.dat = res_word(q_ff);
               if (q_ff.ready && int'(q_ff.idx) < res_len(q_ff.kind)) begin
                  nxt_q.idx = q_ff.idx + 8'h01;             // [R16] [R17]
               end
            end
            default: nxt_q.dat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_ff       <= '0;
         q_ff.ie    <= fcs_pkg::IE_RST;
         q_ff.flash_wait_states   <= fcs_pkg::FWS_RST;
         q_ff.ready <= 1'b1;
         q_ff.st    <= ST_IDLE;
         q_ff.kind  <= RES_NONE;
      end else begin
         q_ff <= nxt_q;
      end
   end

   genvar gp;
   for (gp = 0; gp < NUM_PLANES; gp++) begin : g_plane
      assign plane_busy_o[gp] = q_ff.st == ST_EXEC &&
         ((is_page_op(q_ff.cmd) &&
           int'(q_ff.arg) / PLANE_PAGES == gp) ||
          q_ff.cmd == fcs_pkg::CMD_WIPE);                    // [R4]
   end

   fcs_read_buf #(
      .ADDR_W     (ADDR_W),
      .NUM_PLANES (NUM_PLANES)
   ) u_rbuf (
      .sys_clk_i      (sys_clk_i),
      .rst_n_i        (rst_n_i),
      .fws_i          (q_ff.flash_wait_states),
      .plane_busy_i   (plane_busy_o),
      .rd_req_i       (rd_req_i),
      .rd_instr_i     (rd_instr_i),
      .rd_addr_i      (rd_addr_i),
      .rd_ack_o       (rd_ack_o),
      .rd_data_o      (rd_data_o),
      .fl_req_o       (fl_req_o),
      .fl_line_addr_o (fl_line_addr_o),
      .fl_line_i      (fl_line_i)
   );

   assign wb_ack_o = q_ff.ack;
   assign wb_dat_o = q_ff.dat;
   assign irq_o = q_ff.ready && q_ff.ie;                    // [R11]
   assign nvm_op_o = (q_ff.st == ST_EXEC) ? q_ff.cmd : 4'h0;
   assign nvm_page_o = q_ff.arg;
endmodule // fcs_sequencer

// *** tb/fcs_monitor.sv ***
// Purpose: Port assertions for the flash command sequencer
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to every sequencer instance
module fcs_monitor #(
   parameter logic [7:0] KEY        = 8'h5a,
   parameter int         NUM_PLANES = 1
) (
   input wire logic                  sys_clk_i,
   input wire logic                  rst_n_i,
   input wire logic                  wb_cyc_i,
   input wire logic                  wb_stb_i,
   input wire logic                  wb_we_i,
   input wire logic [7:0]            wb_adr_i,
   input wire logic [31:0]           wb_dat_i,
   input wire logic                  wb_ack_o,
   input wire logic                  irq_o,
   input wire logic                  rd_req_i,
   input wire logic                  rd_ack_o,
   input wire logic                  fl_req_o,
   input wire logic [NUM_PLANES-1:0] plane_busy_o,
   input wire logic [3:0]            nvm_op_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   logic req, busy, badkey;
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign busy = |plane_busy_o;
   assign badkey = req & wb_we_i & (wb_adr_i == 8'h04)
                   & (wb_dat_i[31:24] != KEY) & (nvm_op_o == 4'h0);
   property p_wb_ans; req |=> wb_ack_o; endproperty
   a_wb_ans: assert property (p_wb_ans)
      else $error("late bus ack");
   property p_wb_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_wb_pulse: assert property (p_wb_pulse)
      else $error("long bus ack");
   property p_rd_ans; rd_req_i && !rd_ack_o |-> ##[1:100] rd_ack_o;
   endproperty
   a_rd_ans: assert property (p_rd_ans)
      else $error("read not acked");
   property p_rd_pulse; rd_ack_o |=> !rd_ack_o; endproperty
   a_rd_pulse: assert property (p_rd_pulse)
      else $error("long read ack");
   property p_fetch_free; $rose(fl_req_o) |-> !busy; endproperty
   a_fetch_free: assert property (p_fetch_free)
      else $error("fetch on busy plane");
   property p_op_code;
      nvm_op_o inside {[4'h0:4'h5], [4'h8:4'hd]};
   endproperty
   a_op_code: assert property (p_op_code)
      else $error("undefined op");
   property p_bad_key; badkey |=> (nvm_op_o == 4'h0) [*2]; endproperty
   a_bad_key: assert property (p_bad_key)
      else $error("bad key started");
   property p_busy_hold; $rose(busy) |-> busy [*8]; endproperty
   a_busy_hold: assert property (p_busy_hold)
      else $error("op ended early");
   property p_irq_busy; busy |-> !irq_o; endproperty
   a_irq_busy: assert property (p_irq_busy)
      else $error("irq while busy");
   c_busy: cover property ($rose(busy));
   c_irq: cover property ($rose(irq_o));
   c_fetch: cover property ($rose(fl_req_o));
endmodule // fcs_monitor

bind fcs_sequencer fcs_monitor #(.KEY(KEY), .NUM_PLANES(NUM_PLANES)) mon_u (
   .sys_clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_dat_i, .wb_ack_o, .irq_o, .rd_req_i, .rd_ack_o, .fl_req_o,
   .plane_busy_o, .nvm_op_o);

// *** tb/fcs_array_model.sv ***
// Purpose: Flash array model returning one 128-bit line per fetch
// Assumes: Line index is steady while the fetch request is high
// Notes:   Word k of line i reads 5a000000 | i<<4 | k<<2
module fcs_array_model #(
   parameter int LW = 13
) (
   input  wire logic          sys_clk_i,
   input  wire logic          fl_req_i,
   input  wire logic [LW-1:0] line_addr_i,
   output logic      [127:0]  line_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [127:0] pat;
   logic [127:0] last_q;
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         pat[32*k +: 32] = 32'h5a000000 | (32'(line_addr_i) << 4)
                           | 32'(k << 2);
      end
   end
   // Idle lines toggle so a stale sample shows
   always_ff @(posedge sys_clk_i) last_q <= line_o;
   assign line_o = fl_req_i ? pat : ~last_q;
endmodule // fcs_array_model

// *** tb/fcs_sequencer_tb.sv ***
// Purpose: Self-checking bench for the flash command sequencer
// Assumes: Short program and wipe counts, classic bus master
// Notes:   Random picks come from a fixed seed
module fcs_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] KEY = 8'h5a;
   logic sys_clk_i = 1'b0, rst_n_i = 1'b0, cyc = 1'b0, stb = 1'b0;
   logic we = 1'b0, rd_req = 1'b0, rd_ins = 1'b0;
   logic [7:0]   adr = 8'h00;
   logic [31:0]  wdat = '0, rdat, st, dat_o, rd_data;
   logic [16:0]  rd_addr = '0, a;
   logic         ack, irq, rd_ack, fl_req, busy;
   logic [12:0]  fl_addr;
   logic [127:0] line;
   logic [3:0]   op;
   logic [15:0]  pg, p;
   logic [3:0]   bad [4] = '{4'h6, 4'h7, 4'he, 4'hf};
   int failures = 0, n_compared = 0, n, k;
   fcs_sequencer #(.PROG_CYC(20), .WIPE_CYC(40)) dut_u (
      .sys_clk_i, .rst_n_i, .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq),
      .rd_req_i(rd_req), .rd_instr_i(rd_ins), .rd_addr_i(rd_addr),
      .rd_ack_o(rd_ack), .rd_data_o(rd_data), .fl_req_o(fl_req),
      .fl_line_addr_o(fl_addr), .fl_line_i(line), .plane_busy_o(busy),
      .nvm_op_o(op), .nvm_page_o(pg));
   fcs_array_model arr_u (.sys_clk_i, .fl_req_i(fl_req),
      .line_addr_i(fl_addr), .line_o(line));
   initial forever #5 sys_clk_i = ~sys_clk_i;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d, output logic [31:0] r);
      @(posedge sys_clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= d;
      do @(posedge sys_clk_i); while (ack !== 1'b1);
      r = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic cmd(input logic [7:0] ky, input logic [3:0] c,
                      input logic [15:0] ar);
      wb(1'b1, 8'h04, {ky, ar, 4'h0, c}, rdat);
      do wb(1'b0, 8'h08, 32'h0, st); while (st[0] !== 1'b1);
   endtask
   task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
      wb(1'b0, ad, 32'h0, rdat);
      chk(rdat, e);
   endtask
   task automatic rdp(input logic [16:0] ad, input logic ins);
      k = 0;
      @(posedge sys_clk_i);
      rd_req <= 1'b1;
      rd_addr <= ad;
      rd_ins <= ins;
      do begin
         @(posedge sys_clk_i);
         k++;
      end while (rd_ack !== 1'b1);
      rd_req <= 1'b0;
      chk(rd_data, 32'h5a000000 | {15'h0, ad[16:2], 2'b00});
   endtask
   function automatic logic [31:0] dsc(input int i);
      if (i == 0 || i == 3) return 32'h1;
      if (i == 1 || i == 4) return 32'h20000;
      if (i == 2) return 32'h100;
      if (i == 5) return 32'h10;
      return (i < 22) ? 32'h2000 : 32'h0;
   endfunction
   task automatic end_sim();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #400000;
      failures++;
      end_sim();
   end
   initial begin
      n = $urandom(32'h3213e9cb);
      p = 16'($urandom % 512);
      repeat (3) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      rchk(8'h08, 32'h1);
      wb(1'b1, 8'h00, 32'h401, rdat);
      chk(32'(irq), 32'h1);
      rchk(8'h10, 32'h0);
      $display("reset done");
      foreach (bad[i]) begin
         cmd(KEY, bad[i], 16'h0);
         chk(st, 32'h3);
      end
      cmd(KEY ^ (8'h1 << ($urandom % 8)), 4'h1, 16'h0);
      chk(st, 32'h3);
      rchk(8'h08, 32'h1);
      $display("errors done");
      cmd(KEY, 4'h0, 16'h0);
      for (int i = 0; i < 24; i++) begin
         rchk(8'h0c, dsc(i));
      end
      $display("descriptor done");
      cmd(KEY, 4'h8, p);
      cmd(KEY, 4'h1, p);
      chk(st, 32'h5);
      rchk(8'h0c, 32'h0);
      cmd(KEY, 4'ha, 16'h0);
      rchk(8'h0c, 32'h1 << (p / 32));
      rchk(8'h0c, 32'h0);
      $display("lock done");
      for (int c = 1; c <= 5; c++) begin
         cmd(KEY, 4'h9, p);
         wb(1'b1, 8'h04, {KEY, p, 4'h0, 4'(c)}, rdat);
         @(posedge sys_clk_i);
         chk({busy, op, pg}, {1'b1, 4'(c), p});
         chk(32'(irq), 32'h0);
         wb(1'b0, 8'h08, 32'h0, st);
         chk(st, 32'h0);
         while (st[0] !== 1'b1) wb(1'b0, 8'h08, 32'h0, st);
         cmd(KEY, 4'h1, p);
         chk(st, (c == 2 || c == 4) ? 32'h5 : 32'h1);
         chk(32'(irq), 32'h1);
      end
      $display("program done");
      n = $urandom % 2;
      for (int s = 0; s < 2; s++) begin
         cmd(KEY, 4'hb + 4'(s), 16'(n));
         cmd(KEY, 4'hd, 16'h0);
         rchk(8'h0c, (s == 0) ? 32'h1 << n : 32'h0);
      end
      $display("nv bits done");
      a = 17'($urandom) & 17'h0ffe0;
      rdp(a, 1'b1);
      chk(k, 6);
      for (int i = 1; i < 4; i++) begin
         rdp(a | 17'(i << 2), 1'b1);
         chk(k, 2);
      end
      a = a ^ 17'h10000;
      rdp(a, 1'b0);
      chk(k, 6);
      rdp(a | 17'h4, 1'b0);
      repeat (10) @(posedge sys_clk_i);
      rdp(a + 17'h10, 1'b0);
      chk(32'(k < 6), 32'h1);
      $display("read port done");
      end_sim();
   end
endmodule // fcs_sequencer_tb
